// ===== rtl/bel_flag.sv
// sticky write-one-to-clear flag whose set beats a clear in the same cycle
`timescale 1ns/100ps

module bel_flag (
    input wire logic aclk,    // system clock
    input wire logic aresetn, // synchronous reset, active low
    input wire logic set,     // hardware event
    input wire logic clr,     // software wrote one to this bit
    output logic q            // flag state
);
    logic next_q;

    always_comb begin
        next_q = q;
        if (clr) begin
            next_q = 1'b0;
        end
        if (set) begin
            next_q = 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q <= 1'b0;
        end else begin
            q <= next_q;
        end
    end

    sticky_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
        set |=> q)
        else $error("flag lost an event");

endmodule // bel_flag

// ===== rtl/bel_map.svh
// register offsets, field positions and reset values of the bridge error logger
`ifndef BEL_MAP_SVH
`define BEL_MAP_SVH

`define BEL_ADDR_W 16
`define BEL_LOG_OFFSET 16'h0880
`define BEL_MASK_OFFSET 16'h0884
`define BEL_FAIL_ADDR_OFFSET 16'h1040

`define BEL_BIT_PARITY 0
`define BEL_BIT_SYSERR 1
`define BEL_BIT_TABORT 2
`define BEL_BIT_BADMAP 3
`define BEL_BIT_SUMMARY 4
`define BEL_BIT_OVERFLOW 23
`define BEL_BIT_DROPPED 24

`define BEL_LOG_RESET 32'h0000_0000
`define BEL_MASK_RESET 32'h0000_0000
`define BEL_FAIL_ADDR_RESET 32'h0000_0000

`define BEL_RESP_OKAY 2'h0
`define BEL_RESP_SLVERR 2'h2

`endif

// ===== rtl/bel_pkg.sv
// types shared by the bridge error logger
package bel_pkg;

    // one-cycle strobes from the bridge's pci master and target state machines
    typedef struct packed {
        logic overflow;      // inbound transaction refused, buffers full
        logic bad_map;       // scatter/gather hit an invalid page table entry
        logic target_abort;  // master state machine saw target abort
        logic abort_on_read; // qualifies target_abort: the cycle was a read
        logic special_cycle; // qualifies target_abort: the cycle was a special cycle
        logic serr_seen;     // target state machine saw SERR# low
        logic perr_seen;     // master state machine saw PERR# low
    } bel_pci_evt_t;

    typedef enum logic {
        BEL_WR_WAIT,
        BEL_WR_RESP
    } bel_wr_state_t;

    typedef enum logic {
        BEL_RD_WAIT,
        BEL_RD_RESP
    } bel_rd_state_t;

endpackage

// ===== rtl/bel_top.sv
// bridge pci error log, failing address capture and axi4-lite register slave
//
// The AXI4-Lite interface to the registers was left to the implementer.
`timescale 1ns/100ps
`include "bel_map.svh"

module bel_top #(
    parameter int ADDR_W = `BEL_ADDR_W
) (
    input wire logic aclk,                   // system clock, 25 MHz
    input wire logic aresetn,                // synchronous reset, active low
    input wire logic [ADDR_W-1:0] awaddr,    // write address
    input wire logic [2:0] awprot,           // write protection, unused
    input wire logic awvalid,                // write address valid
    output logic awready,                    // write address ready
    input wire logic [31:0] wdata,           // write data
    input wire logic [3:0] wstrb,            // write byte strobes
    input wire logic wvalid,                 // write data valid
    output logic wready,                     // write data ready
    output logic [1:0] bresp,                // write response
    output logic bvalid,                     // write response valid
    input wire logic bready,                 // write response ready
    input wire logic [ADDR_W-1:0] araddr,    // read address
    input wire logic [2:0] arprot,           // read protection, unused
    input wire logic arvalid,                // read address valid
    output logic arready,                    // read address ready
    output logic [31:0] rdata,               // read data
    output logic [1:0] rresp,                // read response
    output logic rvalid,                     // read data valid
    input wire logic rready,                 // read data ready
    input wire bel_pkg::bel_pci_evt_t pci_evt, // error strobes from pci state machines
    input wire logic [63:0] pci_addr,        // address of the current pci transaction
    output logic fill_error,                 // fill error pulse to the system bus
    output logic serr_n_o,                   // SERR# output level
    output logic serr_n_oe,                  // SERR# output enable
    output logic irq                         // level interrupt
);
    // flag vector order: parity, syserr, tabort, badmap, overflow, dropped
    localparam int NFLAG = 6;

    logic [NFLAG-1:0] flags;
    logic [NFLAG-1:0] flag_set;
    logic [NFLAG-1:0] flag_clr;
    logic [3:0] pci_ev;
    logic [4:0] err_ev;
    logic locked;
    logic summary;
    logic [31:0] log_word;
    logic [31:0] mask;
    logic [31:0] next_mask;
    logic [31:0] fail_addr;
    logic [31:0] next_fail_addr;
    logic next_fill_error;
    logic next_serr_n_oe;
    logic next_irq;

    bel_pkg::bel_wr_state_t wr_state;
    bel_pkg::bel_wr_state_t next_wr_state;
    logic aw_held;
    logic next_aw_held;
    logic w_held;
    logic next_w_held;
    logic [ADDR_W-1:0] wr_addr;
    logic [ADDR_W-1:0] next_wr_addr;
    logic [31:0] wr_data;
    logic [31:0] next_wr_data;
    logic [3:0] wr_strb;
    logic [3:0] next_wr_strb;
    logic next_awready;
    logic next_wready;
    logic next_bvalid;
    logic [1:0] next_bresp;
    logic wr_fire;

    bel_pkg::bel_rd_state_t rd_state;
    bel_pkg::bel_rd_state_t next_rd_state;
    logic next_arready;
    logic next_rvalid;
    logic [31:0] next_rdata;
    logic [1:0] next_rresp;

    // ---------------- error logging ----------------
    always_comb begin
        pci_ev = '0;
        pci_ev[0] = pci_evt.perr_seen;
        pci_ev[1] = pci_evt.serr_seen;
        pci_ev[2] = pci_evt.target_abort && !pci_evt.special_cycle;
        pci_ev[3] = pci_evt.bad_map;
    end

    assign err_ev = {pci_evt.overflow, pci_ev};
    assign summary = |flags[3:0];
    assign locked = |flags[4:0];

    always_comb begin
        flag_set = '0;
        flag_set[4:0] = locked ? 5'h00 : err_ev;
        flag_set[5] = locked && (|err_ev);
    end

    always_comb begin
        flag_clr = '0;
        if (wr_fire && wr_addr == ADDR_W'(`BEL_LOG_OFFSET)) begin
            flag_clr[0] = wr_strb[0] && wr_data[`BEL_BIT_PARITY];
            flag_clr[1] = wr_strb[0] && wr_data[`BEL_BIT_SYSERR];
            flag_clr[2] = wr_strb[0] && wr_data[`BEL_BIT_TABORT];
            flag_clr[3] = wr_strb[0] && wr_data[`BEL_BIT_BADMAP];
            flag_clr[4] = wr_strb[2] && wr_data[`BEL_BIT_OVERFLOW];
            flag_clr[5] = wr_strb[3] && wr_data[`BEL_BIT_DROPPED];
        end
    end

    for (genvar i = 0; i < NFLAG; i++) begin : g_flag
        bel_flag u_flag (
            .aclk(aclk),
            .aresetn(aresetn),
            .set(flag_set[i]),
            .clr(flag_clr[i]),
            .q(flags[i])
        );
    end

    always_comb begin
        log_word = `BEL_LOG_RESET;
        log_word[`BEL_BIT_PARITY] = flags[0];
        log_word[`BEL_BIT_SYSERR] = flags[1];
        log_word[`BEL_BIT_TABORT] = flags[2];
        log_word[`BEL_BIT_BADMAP] = flags[3];
        log_word[`BEL_BIT_SUMMARY] = summary;
        log_word[`BEL_BIT_OVERFLOW] = flags[4];
        log_word[`BEL_BIT_DROPPED] = flags[5];
    end

    always_comb begin
        next_fail_addr = fail_addr;
        // low word only, also for dual cycles
        if (!locked && (|pci_ev)) begin
            next_fail_addr = pci_addr[31:0];
        end
        next_fill_error = pci_evt.target_abort && pci_evt.abort_on_read;
        next_serr_n_oe = pci_evt.target_abort;
        next_irq = |(log_word & mask);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fail_addr <= `BEL_FAIL_ADDR_RESET;
            fill_error <= 1'b0;
            serr_n_oe <= 1'b0;
            serr_n_o <= 1'b1;
            irq <= 1'b0;
            mask <= `BEL_MASK_RESET;
        end else begin
            fail_addr <= next_fail_addr;
            fill_error <= next_fill_error;
            serr_n_oe <= next_serr_n_oe;
            serr_n_o <= !next_serr_n_oe;
            irq <= next_irq;
            mask <= next_mask;
        end
    end

    // ---------------- axi4-lite write ----------------
    assign wr_fire = (wr_state == bel_pkg::BEL_WR_WAIT) && aw_held && w_held;

    always_comb begin
        next_wr_state = wr_state;
        next_aw_held = aw_held;
        next_w_held = w_held;
        next_wr_addr = wr_addr;
        next_wr_data = wr_data;
        next_wr_strb = wr_strb;
        next_bvalid = bvalid;
        next_bresp = bresp;
        next_mask = mask;
        unique case (wr_state)
            bel_pkg::BEL_WR_WAIT: begin
                if (awvalid && awready) begin
                    next_aw_held = 1'b1;
                    next_wr_addr = awaddr;
                end
                if (wvalid && wready) begin
                    next_w_held = 1'b1;
                    next_wr_data = wdata;
                    next_wr_strb = wstrb;
                end
                if (wr_fire) begin
                    next_aw_held = 1'b0;
                    next_w_held = 1'b0;
                    next_bvalid = 1'b1;
                    next_bresp = `BEL_RESP_OKAY;
                    next_wr_state = bel_pkg::BEL_WR_RESP;
                    if (wr_addr == ADDR_W'(`BEL_MASK_OFFSET)) begin
                        for (int b = 0; b < 4; b++) begin
                            if (wr_strb[b]) begin
                                next_mask[8*b +: 8] = wr_data[8*b +: 8];
                            end
                        end
                    end else if (wr_addr != ADDR_W'(`BEL_LOG_OFFSET)
                                 && wr_addr != ADDR_W'(`BEL_FAIL_ADDR_OFFSET)) begin
                        next_bresp = `BEL_RESP_SLVERR;
                    end
                end
            end
            bel_pkg::BEL_WR_RESP: begin
                if (bready) begin
                    next_bvalid = 1'b0;
                    next_wr_state = bel_pkg::BEL_WR_WAIT;
                end
            end
        endcase
        // ready only while that half is still missing and no response is open
        next_awready = (next_wr_state == bel_pkg::BEL_WR_WAIT) && !next_aw_held;
        next_wready = (next_wr_state == bel_pkg::BEL_WR_WAIT) && !next_w_held;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wr_state <= bel_pkg::BEL_WR_WAIT;
            aw_held <= 1'b0;
            w_held <= 1'b0;
            wr_addr <= '0;
            wr_data <= '0;
            wr_strb <= '0;
            awready <= 1'b0;
            wready <= 1'b0;
            bvalid <= 1'b0;
            bresp <= `BEL_RESP_OKAY;
        end else begin
            wr_state <= next_wr_state;
            aw_held <= next_aw_held;
            w_held <= next_w_held;
            wr_addr <= next_wr_addr;
            wr_data <= next_wr_data;
            wr_strb <= next_wr_strb;
            awready <= next_awready;
            wready <= next_wready;
            bvalid <= next_bvalid;
            bresp <= next_bresp;
        end
    end

    // ---------------- axi4-lite read ----------------
    always_comb begin
        next_rd_state = rd_state;
        next_arready = arready;
        next_rvalid = rvalid;
        next_rdata = rdata;
        next_rresp = rresp;
        unique case (rd_state)
            bel_pkg::BEL_RD_WAIT: begin
                next_arready = 1'b1;
                if (arvalid && arready) begin
                    next_arready = 1'b0;
                    next_rvalid = 1'b1;
                    next_rresp = `BEL_RESP_OKAY;
                    next_rd_state = bel_pkg::BEL_RD_RESP;
                    if (araddr == ADDR_W'(`BEL_LOG_OFFSET)) begin
                        next_rdata = log_word;
                    end else if (araddr == ADDR_W'(`BEL_MASK_OFFSET)) begin
                        next_rdata = mask;
                    end else if (araddr == ADDR_W'(`BEL_FAIL_ADDR_OFFSET)) begin
                        next_rdata = fail_addr;
                    end else begin
                        next_rdata = 32'h0000_0000;
                        next_rresp = `BEL_RESP_SLVERR;
                    end
                end
            end
            bel_pkg::BEL_RD_RESP: begin
                if (rready) begin
                    next_rvalid = 1'b0;
                    next_arready = 1'b1;
                    next_rd_state = bel_pkg::BEL_RD_WAIT;
                end
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rd_state <= bel_pkg::BEL_RD_WAIT;
            arready <= 1'b0;
            rvalid <= 1'b0;
            rdata <= 32'h0000_0000;
            rresp <= `BEL_RESP_OKAY;
        end else begin
            rd_state <= next_rd_state;
            arready <= next_arready;
            rvalid <= next_rvalid;
            rdata <= next_rdata;
            rresp <= next_rresp;
        end
    end

    // ---------------- checks ----------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    logic rd_was_log;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rd_was_log <= 1'b0;
        end else if (arvalid && arready) begin
            rd_was_log <= (araddr == ADDR_W'(`BEL_LOG_OFFSET));
        end
    end

    sequence log_clear_write(int b);
        wr_fire && wr_addr == ADDR_W'(`BEL_LOG_OFFSET) && wr_strb[0] && wr_data[b];
    endsequence

    sequence both_halves_taken;
        awvalid && awready && wvalid && wready;
    endsequence

    summary_read_a: assert property (rvalid && rd_was_log |-> rdata[4] == (|rdata[3:0]))
        else $error("summary bit differs from or of pci flags");
    addr_frozen_a: assert property (summary && $past(summary) |-> $stable(fail_addr))
        else $error("failing address changed while summary set");
    addr_capture_a: assert property (!locked && (|pci_ev) |=> fail_addr == $past(pci_addr[31:0]))
        else $error("failing address not captured");
    dropped_flag_a: assert property (locked && (|err_ev) |=> flags[5])
        else $error("locked error not reported as dropped");
    // software may clear the flag in the same cycle it is shown, so that clear excuses it
    overflow_flag_a: assert property (!locked && pci_evt.overflow
                                      |=> log_word[23] ##1 (flags[4] || $past(flag_clr[4])))
        else $error("overflow not logged");
    badmap_flag_a: assert property (!locked && pci_evt.bad_map |=> log_word[3] && log_word[4])
        else $error("bad map entry not logged");
    abort_flag_a: assert property (!locked && pci_evt.target_abort && !pci_evt.special_cycle
                                   |=> flags[2])
        else $error("target abort not logged");
    fill_error_a: assert property (pci_evt.target_abort && pci_evt.abort_on_read
                                   |=> fill_error ##1 !fill_error || $past(pci_evt.target_abort))
        else $error("fill error missing on aborted read");
    syserr_flag_a: assert property (!locked && pci_evt.serr_seen |=> flags[1])
        else $error("system error not logged");
    serr_drive_a: assert property (pci_evt.target_abort |=> serr_n_oe && !serr_n_o)
        else $error("SERR# not driven on target abort");
    parity_flag_a: assert property (!locked && pci_evt.perr_seen |=> flags[0])
        else $error("parity error not logged");
    lock_hold_a: assert property (locked && !(|flag_clr) |=> $stable(flags[4:0]))
        else $error("locked log changed without a clear");
    w1c_clear_a: assert property (log_clear_write(0) and !pci_evt.perr_seen |=> !flags[0])
        else $error("writing one did not clear the parity flag");
    write_answer_a: assert property (both_halves_taken |=> wr_fire ##1 bvalid)
        else $error("write response late");

endmodule // bel_top

// ===== testbench/bel_pci_agent.sv
// pci-side agent model: raises error strobes and resolves the SERR# wire
`timescale 1ns/100ps

module bel_pci_agent (
    input wire logic aclk, // system clock
    input wire logic go, // present the events this cycle
    input wire bel_pkg::bel_pci_evt_t evt_in, // events requested by the bench
    input wire logic [63:0] addr_in, // address of the flagged transaction
    input wire logic serr_n_o, // device SERR# level
    input wire logic serr_n_oe, // device SERR# enable
    output bel_pkg::bel_pci_evt_t pci_evt, // strobes to the logger
    output logic [63:0] pci_addr, // pci address bus
    output logic serr_n // resolved SERR# wire
);
    logic [63:0] last = 64'h0;

    // a released bus shows the inverse so a stale value never matches by luck
    always @(posedge aclk) begin
        if (go) begin
            last <= addr_in;
        end
    end
    assign pci_evt = go ? evt_in : '0;
    assign pci_addr = go ? addr_in : ~last;
    assign serr_n = serr_n_oe ? serr_n_o : 1'b1;
endmodule // bel_pci_agent

// ===== testbench/bridge_error_logger_tb.sv
// self-checking bench for the bridge error logger
`timescale 1ns/100ps
`include "bel_map.svh"

module bridge_error_logger_tb;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [15:0] awaddr = 16'h0, araddr = 16'h0;
    logic [2:0] awprot = 3'h0, arprot = 3'h0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'h0;
    logic awready, wready, bvalid, arready, rvalid, fill_error, serr_n_o, serr_n_oe, irq;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic go = 1'b0;
    bel_pkg::bel_pci_evt_t evt_in = '0;
    bel_pkg::bel_pci_evt_t pci_evt;
    logic [63:0] addr_in = 64'h0;
    logic [63:0] pci_addr;
    logic serr_n;
    int n_fail = 0;
    int samples_checked = 0;
    logic [31:0] m_log = 32'h0, m_mask = 32'h0, m_fail = 32'h0;
    logic fresh = 1'b1;

    always #20 aclk = ~aclk;

    bel_top u_dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(awprot),
        .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
        .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arprot(arprot), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid), .rready(rready), .pci_evt(pci_evt), .pci_addr(pci_addr),
        .fill_error(fill_error), .serr_n_o(serr_n_o), .serr_n_oe(serr_n_oe), .irq(irq));

    bel_pci_agent u_agent (.aclk(aclk), .go(go), .evt_in(evt_in), .addr_in(addr_in),
        .serr_n_o(serr_n_o), .serr_n_oe(serr_n_oe), .pci_evt(pci_evt), .pci_addr(pci_addr),
        .serr_n(serr_n));

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("Error t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        chk_word({31'h0, got}, {31'h0, exp});
    endtask

    task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
        chk_word({30'h0, got}, {30'h0, exp});
    endtask

    function automatic logic [31:0] logword();
        return m_log | {27'h0, |m_log[3:0], 4'h0};
    endfunction

    function automatic logic [31:0] lanes(input logic [3:0] s);
        return {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    endfunction

    function automatic logic mapped(input logic [15:0] a);
        return a == `BEL_LOG_OFFSET || a == `BEL_MASK_OFFSET || a == `BEL_FAIL_ADDR_OFFSET;
    endfunction

    task automatic reg_wr(input logic [15:0] a, input logic [31:0] d, input logic [3:0] s);
        logic [1:0] r;
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awprot <= 3'($urandom);
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        forever begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid) begin
                r = bresp;
                break;
            end
        end
        bready <= 1'b0;
        // write-one-to-clear flags, byte-lane mask
        if (a == `BEL_LOG_OFFSET) m_log &= ~(d & lanes(s) & 32'h0180_000f);
        if (a == `BEL_MASK_OFFSET) m_mask = (m_mask & ~lanes(s)) | (d & lanes(s));
        chk_resp(r, mapped(a) ? `BEL_RESP_OKAY : `BEL_RESP_SLVERR);
        @(posedge aclk);
    endtask

    task automatic reg_rd(input logic [15:0] a);
        logic [31:0] d;
        logic [1:0] r;
        araddr <= a;
        arprot <= 3'($urandom);
        arvalid <= 1'b1;
        rready <= 1'b1;
        forever begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid) begin
                d = rdata;
                r = rresp;
                break;
            end
        end
        rready <= 1'b0;
        chk_resp(r, mapped(a) ? `BEL_RESP_OKAY : `BEL_RESP_SLVERR);
        if (a == `BEL_LOG_OFFSET) chk_word(d, logword());
        if (a == `BEL_MASK_OFFSET) chk_word(d, m_mask);
        // the captured address means nothing while the summary is clear
        if (a == `BEL_FAIL_ADDR_OFFSET && (fresh || |m_log[3:0])) chk_word(d, m_fail);
        if (!mapped(a)) chk_word(d, 32'h0);
        chk_bit(irq, (logword() & m_mask) != 32'h0);
        @(posedge aclk);
    endtask

    task automatic pulse(input bel_pkg::bel_pci_evt_t e, input logic [63:0] a);
        logic [31:0] s;
        go <= 1'b1;
        evt_in <= e;
        addr_in <= a;
        @(posedge aclk);
        go <= 1'b0;
        s = {7'h0, e.overflow, 19'h0, e.bad_map, e.target_abort & !e.special_cycle,
             e.serr_seen, e.perr_seen};
        if (s != 32'h0) begin
            fresh = 1'b0;
            if ((m_log & 32'h0080_000f) != 32'h0) begin
                m_log[24] = 1'b1;
            end else begin
                m_log |= s;
                if (s[3:0] != 4'h0) m_fail = a[31:0];
            end
        end
        #1;
        chk_bit(fill_error, e.target_abort & e.abort_on_read);
        chk_bit(serr_n, !e.target_abort);
        @(posedge aclk);
    endtask

    initial begin
        repeat (40000) @(posedge aclk);
        n_fail++;
        end_of_test();
    end

    initial begin
        bel_pkg::bel_pci_evt_t kinds [5] = '{7'h01, 7'h02, 7'h10, 7'h20, 7'h40};
        bel_pkg::bel_pci_evt_t aborts [4] = '{7'h10, 7'h18, 7'h14, 7'h1c};
        void'($urandom(32'h527d));
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        reg_rd(`BEL_LOG_OFFSET);
        reg_rd(`BEL_MASK_OFFSET);
        reg_wr(`BEL_FAIL_ADDR_OFFSET, $urandom, 4'hf);
        reg_rd(`BEL_FAIL_ADDR_OFFSET);
        reg_wr(16'h0100, $urandom, 4'hf);
        reg_rd(16'h0100);
        $display("test reset and decode done");
        for (int k = 0; k < 5; k++) begin
            pulse(kinds[k], {$urandom, $urandom});
            reg_rd(`BEL_LOG_OFFSET);
            reg_rd(`BEL_FAIL_ADDR_OFFSET);
            pulse(kinds[(k + 1) % 5], {$urandom, $urandom});
            reg_rd(`BEL_LOG_OFFSET);
            reg_rd(`BEL_FAIL_ADDR_OFFSET);
            reg_wr(`BEL_LOG_OFFSET, 32'h0000_0010, 4'hf);
            reg_rd(`BEL_LOG_OFFSET);
            reg_wr(`BEL_LOG_OFFSET, 32'hffff_ffff, 4'hf);
            reg_rd(`BEL_LOG_OFFSET);
        end
        $display("test single events done");
        for (int k = 0; k < 4; k++) begin
            pulse(aborts[k], {$urandom, $urandom});
            reg_rd(`BEL_LOG_OFFSET);
            reg_wr(`BEL_LOG_OFFSET, 32'hffff_ffff, 4'hf);
        end
        $display("test target abort done");
        reg_wr(`BEL_MASK_OFFSET, 32'h0000_0002, 4'hf);
        reg_rd(`BEL_MASK_OFFSET);
        pulse(kinds[0], {$urandom, $urandom});
        reg_rd(`BEL_LOG_OFFSET);
        reg_wr(`BEL_LOG_OFFSET, 32'h0000_0001, 4'h1);
        pulse(kinds[1], {$urandom, $urandom});
        reg_rd(`BEL_LOG_OFFSET);
        reg_wr(`BEL_MASK_OFFSET, 32'h0, 4'hf);
        reg_rd(`BEL_MASK_OFFSET);
        reg_wr(`BEL_MASK_OFFSET, 32'h0180_001f, 4'hf);
        reg_rd(`BEL_LOG_OFFSET);
        reg_wr(`BEL_LOG_OFFSET, 32'hffff_ffff, 4'hf);
        reg_rd(`BEL_LOG_OFFSET);
        $display("test interrupt done");
        repeat (200) begin
            case ($urandom % 4)
                0: reg_wr(`BEL_LOG_OFFSET, $urandom, 4'($urandom));
                1: reg_wr(`BEL_MASK_OFFSET, $urandom & 32'h0180_001f, 4'($urandom));
                default: pulse(7'($urandom) & 7'h7b, {$urandom, $urandom});
            endcase
            reg_rd(`BEL_LOG_OFFSET);
            reg_rd(`BEL_FAIL_ADDR_OFFSET);
        end
        $display("test random traffic done");
        end_of_test();
    end
endmodule // bridge_error_logger_tb
